// ===== uqs_pkg.sv
// Purpose: constants for the shared request queue event counter
// Assumes: one uncore clock, event code and unit mask as plain inputs
// Notes:   event codes and masks are the hardware's selection values
// Behaviour
// - 03h/20h counts write tracker miss allocations
// - 03h/40h counts snoop tracker miss allocations
// - 04h/01h counts link input busy cycles
// - 04h/02h counts memory controller input busy cycles
// - 04h/04h counts cache input busy cycles
// - 04h/08h counts cores 0/2 input busy
// - 04h/10h counts cores 1/3 input busy
// - 05h/01h counts link or memory output busy
// - 05h/02h counts cache output busy cycles
// - 05h/04h counts cores output busy cycles
// - mask 01h counts responses, line absent
// - mask 02h counts responses, line shared
// - mask 04h counts exclusive hits forwarded shared
// - mask 08h counts modified hits forwarded modified
// - mask 10h counts conflict responses, both homes
// - 06h/20h counts local read-snoop modified responses
package uqs_pkg;
  localparam int unsigned CNT_W = 48;
  localparam logic [7:0] EV_ALLOC    = 8'h03;
  localparam logic [7:0] EV_DATA_IN  = 8'h04;
  localparam logic [7:0] EV_DATA_OUT = 8'h05;
  localparam logic [7:0] EV_SNP_LCL  = 8'h06;
  localparam logic [7:0] EV_SNP_RMT  = 8'h07;
  localparam logic [7:0] UM_WT_MISS  = 8'h20;
  localparam logic [7:0] UM_PP_MISS  = 8'h40;
  localparam logic [7:0] UM_IN_LINK  = 8'h01;
  localparam logic [7:0] UM_IN_MEM   = 8'h02;
  localparam logic [7:0] UM_IN_LLC   = 8'h04;
  localparam logic [7:0] UM_IN_C02   = 8'h08;
  localparam logic [7:0] UM_IN_C13   = 8'h10;
  localparam logic [7:0] UM_OUT_LM   = 8'h01;
  localparam logic [7:0] UM_OUT_LLC  = 8'h02;
  localparam logic [7:0] UM_OUT_CORE = 8'h04;
  localparam logic [7:0] UM_SR_I     = 8'h01;
  localparam logic [7:0] UM_SR_S     = 8'h02;
  localparam logic [7:0] UM_SR_FWD_S = 8'h04;
  localparam logic [7:0] UM_SR_FWD_I = 8'h08;
  localparam logic [7:0] UM_SR_CONF  = 8'h10;
  localparam logic [7:0] UM_SR_WB    = 8'h20;
  // Snoop response class encoding on i_snp_resp_class
  localparam logic [2:0] SR_I     = 3'h0;
  localparam logic [2:0] SR_S     = 3'h1;
  localparam logic [2:0] SR_FWD_S = 3'h2;
  localparam logic [2:0] SR_FWD_I = 3'h3;
  localparam logic [2:0] SR_CONF  = 3'h4;
  localparam logic [2:0] SR_WB    = 3'h5;
endpackage : uqs_pkg

// ===== uqs_event_counter.sv
// Purpose: select one queue event by code and mask and count it
// Assumes: all event inputs are on the uncore clock, sampled as levels each cycle
// Notes:   counter wraps silently; overflow handling lives elsewhere
`timescale 1ns/1ps
module uqs_event_counter
  import uqs_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [7:0]       i_event_code,
  input  wire logic [7:0]       i_unit_mask,
  input  wire logic             i_count_clear,
  input  wire logic             i_write_tracker_miss_alloc,
  input  wire logic             i_snoop_tracker_miss_alloc,
  input  wire logic             i_link_input_busy,
  input  wire logic             i_memctl_input_busy,
  input  wire logic             i_llc_input_busy,
  input  wire logic             i_even_cores_input_busy,
  input  wire logic             i_odd_cores_input_busy,
  input  wire logic             i_link_mem_output_busy,
  input  wire logic             i_llc_output_busy,
  input  wire logic             i_cores_output_busy,
  input  wire logic             i_snp_resp_valid,
  input  wire logic             i_snp_resp_remote,
  input  wire logic [2:0]       i_snp_resp_class,
  output logic                  o_event_hit,
  output logic [CNT_W-1:0]      o_count
);

  // Slot per listed code and mask pair; unlisted pairs have none
  localparam int unsigned NCOND     = 21;
  localparam int unsigned C_WT      = 0;
  localparam int unsigned C_PP      = 1;
  localparam int unsigned C_IN_LINK = 2;
  localparam int unsigned C_IN_MEM  = 3;
  localparam int unsigned C_IN_LLC  = 4;
  localparam int unsigned C_IN_C02  = 5;
  localparam int unsigned C_IN_C13  = 6;
  localparam int unsigned C_OUT_LM  = 7;
  localparam int unsigned C_OUT_LLC = 8;
  localparam int unsigned C_OUT_CR  = 9;
  localparam int unsigned C_L_I     = 10;
  localparam int unsigned C_L_S     = 11;
  localparam int unsigned C_L_FS    = 12;
  localparam int unsigned C_L_FI    = 13;
  localparam int unsigned C_L_CONF  = 14;
  localparam int unsigned C_L_WB    = 15;
  localparam int unsigned C_R_I     = 16;
  localparam int unsigned C_R_S     = 17;
  localparam int unsigned C_R_FS    = 18;
  localparam int unsigned C_R_FI    = 19;
  localparam int unsigned C_R_CONF  = 20;

  // Bit positions of the decoded response class
  localparam int unsigned NCLS      = 6;
  localparam int unsigned K_I       = 0;
  localparam int unsigned K_S       = 1;
  localparam int unsigned K_FWD_S   = 2;
  localparam int unsigned K_FWD_I   = 3;
  localparam int unsigned K_CONF    = 4;
  localparam int unsigned K_WB      = 5;

  // Counter halves; the split keeps each carry chain short
  localparam int unsigned CNT_LO_W  = CNT_W / 2;
  localparam int unsigned CNT_HI_W  = CNT_W - CNT_LO_W;

  logic [NCOND-1:0]    grp_alloc;
  logic [NCOND-1:0]    grp_in;
  logic [NCOND-1:0]    grp_out;
  logic [NCOND-1:0]    grp_lcl;
  logic [NCOND-1:0]    grp_rmt;
  logic [NCOND-1:0]    sel_vec;
  logic [NCOND-1:0]    cond_alloc;
  logic [NCOND-1:0]    cond_in;
  logic [NCOND-1:0]    cond_out;
  logic [NCOND-1:0]    cond_lcl;
  logic [NCOND-1:0]    cond_rmt;
  logic [NCOND-1:0]    cond_vec;
  logic [NCOND-1:0]    match_vec;
  logic [NCLS-1:0]     cls_hot;
  logic                snp_local;
  logic                snp_remote;
  logic                hit_any;
  logic                event_hit_nxt;
  logic                event_hit_r;
  logic                lo_carry;
  logic [CNT_LO_W-1:0] count_lo_nxt;
  logic [CNT_HI_W-1:0] count_hi_nxt;
  logic [CNT_LO_W-1:0] count_lo_r;
  logic [CNT_HI_W-1:0] count_hi_r;

  // Allocation group: only the two miss allocations
  function automatic logic [NCOND-1:0] uqs_sel_alloc(
    input logic [7:0] mask
  );
    logic [NCOND-1:0] sel;
    sel = '0;
    case (mask)
      UM_WT_MISS: sel[C_WT] = 1'b1;
      UM_PP_MISS: sel[C_PP] = 1'b1;
      default:    sel = '0;
    endcase
    return sel;
  endfunction : uqs_sel_alloc

  // Input data ports
  function automatic logic [NCOND-1:0] uqs_sel_in(
    input logic [7:0] mask
  );
    logic [NCOND-1:0] sel;
    sel = '0;
    case (mask)
      UM_IN_LINK: sel[C_IN_LINK] = 1'b1;
      UM_IN_MEM:  sel[C_IN_MEM]  = 1'b1;
      UM_IN_LLC:  sel[C_IN_LLC]  = 1'b1;
      UM_IN_C02:  sel[C_IN_C02]  = 1'b1;
      UM_IN_C13:  sel[C_IN_C13]  = 1'b1;
      default:    sel = '0;
    endcase
    return sel;
  endfunction : uqs_sel_in

  // Output data ports
  function automatic logic [NCOND-1:0] uqs_sel_out(
    input logic [7:0] mask
  );
    logic [NCOND-1:0] sel;
    sel = '0;
    case (mask)
      UM_OUT_LM:   sel[C_OUT_LM]  = 1'b1;
      UM_OUT_LLC:  sel[C_OUT_LLC] = 1'b1;
      UM_OUT_CORE: sel[C_OUT_CR]  = 1'b1;
      default:     sel = '0;
    endcase
    return sel;
  endfunction : uqs_sel_out

  // Both homes share one mask table; remote write-back is not ours
  function automatic logic [NCOND-1:0] uqs_sel_snoop(
    input logic [7:0] mask,
    input logic       remote
  );
    logic [NCOND-1:0] sel;
    sel = '0;
    if (!remote) begin
      case (mask)
        UM_SR_I:     sel[C_L_I]    = 1'b1;
        UM_SR_S:     sel[C_L_S]    = 1'b1;
        UM_SR_FWD_S: sel[C_L_FS]   = 1'b1;
        UM_SR_FWD_I: sel[C_L_FI]   = 1'b1;
        UM_SR_CONF:  sel[C_L_CONF] = 1'b1;
        UM_SR_WB:    sel[C_L_WB]   = 1'b1;
        default:     sel = '0;
      endcase
    end else begin
      case (mask)
        UM_SR_I:     sel[C_R_I]    = 1'b1;
        UM_SR_S:     sel[C_R_S]    = 1'b1;
        UM_SR_FWD_S: sel[C_R_FS]   = 1'b1;
        UM_SR_FWD_I: sel[C_R_FI]   = 1'b1;
        UM_SR_CONF:  sel[C_R_CONF] = 1'b1;
        default:     sel = '0;
      endcase
    end
    return sel;
  endfunction : uqs_sel_snoop

  // Unknown class codes decode to nothing and never count
  function automatic logic [NCLS-1:0] uqs_class_hot(
    input logic [2:0] cls
  );
    logic [NCLS-1:0] hot;
    hot = '0;
    case (cls)
      SR_I:     hot[K_I]     = 1'b1;
      SR_S:     hot[K_S]     = 1'b1;
      SR_FWD_S: hot[K_FWD_S] = 1'b1;
      SR_FWD_I: hot[K_FWD_I] = 1'b1;
      SR_CONF:  hot[K_CONF]  = 1'b1;
      SR_WB:    hot[K_WB]    = 1'b1;
      default:  hot = '0;
    endcase
    return hot;
  endfunction : uqs_class_hot

  // Unlisted event codes leave every group empty
  always_comb begin
    grp_alloc = '0;
    if (i_event_code == EV_ALLOC) begin
      grp_alloc = uqs_sel_alloc(i_unit_mask);
    end
  end

  always_comb begin
    grp_in = '0;
    if (i_event_code == EV_DATA_IN) begin
      grp_in = uqs_sel_in(i_unit_mask);
    end
  end

  always_comb begin
    grp_out = '0;
    if (i_event_code == EV_DATA_OUT) begin
      grp_out = uqs_sel_out(i_unit_mask);
    end
  end

  always_comb begin
    grp_lcl = '0;
    if (i_event_code == EV_SNP_LCL) begin
      grp_lcl = uqs_sel_snoop(i_unit_mask, 1'b0);
    end
  end

  always_comb begin
    grp_rmt = '0;
    if (i_event_code == EV_SNP_RMT) begin
      grp_rmt = uqs_sel_snoop(i_unit_mask, 1'b1);
    end
  end

  assign sel_vec = grp_alloc |
                   grp_in    |
                   grp_out   |
                   grp_lcl   |
                   grp_rmt;

  // Direction split first, class decode shared by both homes
  assign cls_hot = uqs_class_hot(i_snp_resp_class);
  always_comb begin
    snp_local  = i_snp_resp_valid && !i_snp_resp_remote;
    snp_remote = i_snp_resp_valid && i_snp_resp_remote;
  end

  // Byte width per cycle does not matter: one busy cycle, one count
  always_comb begin
    cond_alloc = '0;
    cond_alloc[C_WT] = i_write_tracker_miss_alloc;
    cond_alloc[C_PP] = i_snoop_tracker_miss_alloc;
  end

  always_comb begin
    cond_in = '0;
    cond_in[C_IN_LINK] = i_link_input_busy;
    cond_in[C_IN_MEM]  = i_memctl_input_busy;
    cond_in[C_IN_LLC]  = i_llc_input_busy;
    cond_in[C_IN_C02]  = i_even_cores_input_busy;
    cond_in[C_IN_C13]  = i_odd_cores_input_busy;
  end

  always_comb begin
    cond_out = '0;
    cond_out[C_OUT_LM]  = i_link_mem_output_busy;
    cond_out[C_OUT_LLC] = i_llc_output_busy;
    cond_out[C_OUT_CR]  = i_cores_output_busy;
  end

  always_comb begin
    cond_lcl = '0;
    cond_lcl[C_L_I]    = snp_local && cls_hot[K_I];
    cond_lcl[C_L_S]    = snp_local && cls_hot[K_S];
    cond_lcl[C_L_FS]   = snp_local && cls_hot[K_FWD_S];
    cond_lcl[C_L_FI]   = snp_local && cls_hot[K_FWD_I];
    cond_lcl[C_L_CONF] = snp_local && cls_hot[K_CONF];
    cond_lcl[C_L_WB]   = snp_local && cls_hot[K_WB];
  end

  always_comb begin
    cond_rmt = '0;
    cond_rmt[C_R_I]    = snp_remote && cls_hot[K_I];
    cond_rmt[C_R_S]    = snp_remote && cls_hot[K_S];
    cond_rmt[C_R_FS]   = snp_remote && cls_hot[K_FWD_S];
    cond_rmt[C_R_FI]   = snp_remote && cls_hot[K_FWD_I];
    cond_rmt[C_R_CONF] = snp_remote && cls_hot[K_CONF];
  end

  assign cond_vec = cond_alloc |
                    cond_in    |
                    cond_out   |
                    cond_lcl   |
                    cond_rmt;

  // Only the selected slot can reach the counter
  for (genvar g = 0; g < NCOND; g++) begin : g_match
    assign match_vec[g] = sel_vec[g] & cond_vec[g];
  end

  always_comb begin
    hit_any       = |match_vec;
    event_hit_nxt = hit_any && !i_count_clear;
  end

  // Clear drops a same-cycle hit, so the pulse and count agree
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_hit_r <= 1'b0;
    end else begin
      event_hit_r <= event_hit_nxt;
    end
  end

  // Clear beats a same-cycle hit; counter is software state
  always_comb begin
    lo_carry     = &count_lo_r;
    count_lo_nxt = count_lo_r;
    count_hi_nxt = count_hi_r;
    if (i_count_clear) begin
      count_lo_nxt = '0;
      count_hi_nxt = '0;
    end else if (hit_any) begin
      count_lo_nxt = count_lo_r + CNT_LO_W'(1);
      if (lo_carry) begin
        count_hi_nxt = count_hi_r + CNT_HI_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_lo_r <= '0;
    end else begin
      count_lo_r <= count_lo_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_hi_r <= '0;
    end else begin
      count_hi_r <= count_hi_nxt;
    end
  end

  // Both halves move on one edge, so the joined value never tears
  assign o_event_hit = event_hit_r;
  assign o_count     = {count_hi_r, count_lo_r};

endmodule : uqs_event_counter

// ===== uqs_chk_assertions.sv
// Purpose: port checks for uqs_event_counter
// Assumes: one clock, async active-low reset
// Notes:   hit and count follow a selected event by one edge
`timescale 1ns/1ps
module uqs_chk
  import uqs_pkg::*;
(
  input wire logic             i_clk_sys,
  input wire logic             i_reset_n,
  input wire logic [7:0]       i_event_code,
  input wire logic [7:0]       i_unit_mask,
  input wire logic             i_count_clear,
  input wire logic             i_write_tracker_miss_alloc,
  input wire logic             i_link_input_busy,
  input wire logic             i_llc_output_busy,
  input wire logic             i_snp_resp_valid,
  input wire logic             i_snp_resp_remote,
  input wire logic [2:0]       i_snp_resp_class,
  input wire logic             o_event_hit,
  input wire logic [CNT_W-1:0] o_count
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  function automatic bit s(logic [7:0] c, logic [7:0] m);
    return i_event_code == c && i_unit_mask == m && !i_count_clear;
  endfunction : s
  sequence lcl_absent;
    i_snp_resp_valid && !i_snp_resp_remote && i_snp_resp_class == SR_I;
  endsequence
  hit_inc_a: assert property (o_event_hit |-> o_count == $past(o_count) + 1)
    else $error("hit without count step");
  hold_cnt_a: assert property (!o_event_hit && !$past(i_count_clear) |-> $stable(o_count))
    else $error("count moved without hit");
  clear_zero_a: assert property (i_count_clear |=> o_count == 0 && !o_event_hit)
    else $error("clear ignored");
  wt_hit_a: assert property (s(8'h03, 8'h20) && i_write_tracker_miss_alloc |=> o_event_hit)
    else $error("write tracker miss missed");
  link_hit_a: assert property (s(8'h04, 8'h01) && i_link_input_busy |=> o_event_hit)
    else $error("link busy missed");
  llc_out_a: assert property (s(8'h05, 8'h02) && i_llc_output_busy |=> o_event_hit)
    else $error("cache output busy missed");
  snp_abs_a: assert property (s(8'h06, 8'h01) ##0 lcl_absent |=> o_event_hit)
    else $error("local absent response missed");
  bad_pair_a: assert property (s(8'h07, 8'h20) |=> !o_event_hit)
    else $error("unlisted pair counted");
endmodule : uqs_chk
bind uqs_event_counter uqs_chk i_uqs_chk (.*);

// ===== uqs_event_counter_tb_top.sv
// Purpose: directed bench for uqs_event_counter
// Assumes: inputs move on the falling edge
// Notes:   expected count kept in exp_c
`timescale 1ns/1ps
module uqs_event_counter_tb_top;
  import uqs_pkg::*;
  logic clk = 0, rst_n = 0, clr = 0, sv = 0, rm = 0, hit;
  logic [7:0] ec = 0, um = 0;
  logic [9:0] ev = 0;
  logic [2:0] cl = 0;
  logic [CNT_W-1:0] cnt, exp_c = 0;
  logic [7:0] mk [10] = '{8'h20, 8'h40, 8'h01, 8'h02, 8'h04, 8'h08,
                          8'h10, 8'h01, 8'h02, 8'h04};
  int failures = 0, samples_checked = 0;
  uqs_event_counter i_uqs_event_counter (.i_clk_sys(clk),
    .i_reset_n(rst_n), .i_event_code(ec), .i_unit_mask(um),
    .i_count_clear(clr), .i_write_tracker_miss_alloc(ev[0]),
    .i_snoop_tracker_miss_alloc(ev[1]), .i_link_input_busy(ev[2]),
    .i_memctl_input_busy(ev[3]), .i_llc_input_busy(ev[4]),
    .i_even_cores_input_busy(ev[5]), .i_odd_cores_input_busy(ev[6]),
    .i_link_mem_output_busy(ev[7]), .i_llc_output_busy(ev[8]),
    .i_cores_output_busy(ev[9]), .i_snp_resp_valid(sv),
    .i_snp_resp_remote(rm), .i_snp_resp_class(cl),
    .o_event_hit(hit), .o_count(cnt));
  initial forever #12.5 clk = ~clk;
  task automatic chk(logic [CNT_W-1:0] s, logic [CNT_W-1:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t count %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic run(int b, int n, int inc);
    ev[b] = 1'b1;
    repeat (n) @(negedge clk);
    ev[b] = 1'b0;
    exp_c += CNT_W'(inc * n);
    chk(cnt, exp_c);
    chk(CNT_W'(hit), CNT_W'(inc));
  endtask : run
  task automatic snp(logic [7:0] c, logic [7:0] m, logic r, int k, int inc);
    ec = c; um = m; sv = 1'b1; rm = r; cl = 3'(k);
    @(negedge clk);
    sv = 1'b0;
    exp_c += CNT_W'(inc);
    chk(cnt, exp_c);
    chk(CNT_W'(hit), CNT_W'(inc));
  endtask : snp
  task automatic t_events();
    for (int i = 0; i < 10; i++) begin
      ec = i < 2 ? 8'h03 : i < 7 ? 8'h04 : 8'h05;
      um = mk[i];
      run(i, 3, 1);
      run((i + 1) % 10, 2, 0);
    end
  endtask : t_events
  task automatic t_snoop();
    for (int k = 0; k < 5; k++) begin
      snp(8'h06, 8'h01 << k, 1'b0, k, 1);
      snp(8'h07, 8'h01 << k, 1'b1, k, 1);
      snp(8'h06, 8'h01 << k, 1'b1, k, 0);
    end
    snp(8'h06, 8'h20, 1'b0, 5, 1);
    snp(8'h07, 8'h20, 1'b1, 5, 0);
  endtask : t_snoop
  task automatic t_clear();
    ec = 8'h03; um = 8'h20; ev[0] = 1'b1; clr = 1'b1;
    @(negedge clk);
    ev[0] = 1'b0; clr = 1'b0; exp_c = '0;
    chk(cnt, exp_c);
    chk(CNT_W'(hit), CNT_W'(0));
  endtask : t_clear
  task automatic test_done();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk(cnt, exp_c);
    t_events();
    t_snoop();
    t_clear();
    test_done();
  end
  initial begin
    #20us;
    failures++;
    test_done();
  end
endmodule : uqs_event_counter_tb_top
